// *** verilog/pcs_defs.svh ***
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// register byte addresses
`define PCS_ADDR_CTL 8'h00
`define PCS_ADDR_PLL 8'h04
`define PCS_ADDR_BANK_A 8'h08
`define PCS_ADDR_BANK_B 8'h0C
`define PCS_ADDR_BANK_C 8'h10
`define PCS_ADDR_BANK_D 8'h14
`define PCS_ADDR_FRAC 8'h18
`define PCS_ADDR_STAT 8'h1C
// control register fields
`define PCS_CTL_PLL_BIT 0
`define PCS_CTL_A_BIT 1
`define PCS_CTL_B_BIT 2
`define PCS_CTL_C_BIT 3
`define PCS_CTL_D_BIT 4
`define PCS_CTL_RESYNC_BIT 8
// reset values
`define PCS_CTL_RST 32'h0000_0000
`define PCS_PLL_RST 32'h0001_9001
`define PCS_BANK_RST 32'h0000_0001
`define PCS_FRAC_RST 32'h0000_0000
// bank register fields
`define PCS_BK_DIV_LSB 0
`define PCS_BK_PD_BIT 8
`define PCS_BK_OPD_LSB 12
`define PCS_BK_STY_LSB 16
`define PCS_BK_AMP_LSB 20
// pll register fields
`define PCS_PLL_PS_LSB 0
`define PCS_PLL_FDP_BIT 8
`define PCS_PLL_M_LSB 12
// bank d extra fields
`define PCS_BD_FINT_LSB 24
`define PCS_BD_DIVF_LSB 28
`define PCS_BD_SRC_BIT 30
`define PCS_BD_FRAC_BIT 31
// resync pulse length in cycles
`define PCS_RESYNC_CYC 4
`endif

// *** verilog/pcs_pkg.sv ***
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_LVL_LOW,
    PCS_LVL_MID,
    PCS_LVL_HIGH
  } pcs_level_t;

  // preset decode result, frequencies in kHz
  typedef struct packed {
    logic [19:0] fin_khz;
    logic [21:0] fvco_khz;
  } pcs_preset_t;

  // one output bank's effective configuration
  typedef struct packed {
    logic [7:0] div;
    logic bank_pd;
    logic [3:0] out_pd;
    logic [3:0] style;
    logic [7:0] swing;
  } pcs_bank_cfg_t;
endpackage

// *** verilog/pcs_cfg_if.sv ***
`timescale 1ns/1ns
// pin-side and register-side bank config for one bank
interface pcs_cfg_if;
  logic use_reg;
  pcs_pkg::pcs_bank_cfg_t pin_cfg;
  pcs_pkg::pcs_bank_cfg_t reg_cfg;
  pcs_pkg::pcs_bank_cfg_t eff_cfg;
  modport sel (
    input use_reg,
    input pin_cfg,
    input reg_cfg,
    output eff_cfg
  );
  modport top (
    output use_reg,
    output pin_cfg,
    output reg_cfg,
    input eff_cfg
  );
endinterface

// *** verilog/pcs_bank_sel.sv ***
`timescale 1ns/1ns
// =====================================================================
// per-bank source mux, registered so outputs come from flip-flops
module pcs_bank_sel (
  input wire logic clk_sys,
  input wire logic rst_n,
  pcs_cfg_if.sel cfg
);
  pcs_pkg::pcs_bank_cfg_t eff_q;

  // exactly one source drives the bank at a time
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eff_q <= '0;
    end else begin
      eff_q <= cfg.use_reg ? cfg.reg_cfg : cfg.pin_cfg; // R2 R3
    end
  end

  assign cfg.eff_cfg = eff_q;
endmodule // pcs_bank_sel

// *** verilog/pcs_top.sv ***
// Function
// R1: pins govern every group at power-up
// R2: per-group source bit, pins or registers
// R3: pin-controlled registers keep values, no effect
// R4: registers return to defaults after power loss
// R5: pll group: prescaler, doubler, feedback divider
// R6: banks a-c: divider, powerdowns, style, swing
// R7: bank d adds fractional fields, source pick
// R8: resync restores alignment and fractional output
// R9: host disables outputs around reconfiguration
// R10: divider writes need resync to load
// R11: reference pin picks crystal or clock
// R12: low selects crystal, high selects clock input
// R13: high preset row sets three input/vco pairs
// R14: middle and low rows, vco 2500
// R15: presets same for either reference
// R16: host uses doubler or prescaler, not both
// R17: lock status on dedicated output
// R18: lock low unlocked, high locked
// R19: banks of four, four, two, two outputs
// R20: resync bit clears itself
`timescale 1ns/1ns
`include "pcs_defs.svh"
module pcs_top #(
  parameter int NUM_A = 4,
  parameter int NUM_B = 4,
  parameter int NUM_C = 2,
  parameter int NUM_D = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // strap and status pins, asynchronous
  input wire logic [1:0] freq_preset_hi_pins,
  input wire logic [1:0] freq_preset_lo_pins,
  input wire logic ref_select_pin,
  input wire logic [1:0] bank_a_pins,
  input wire logic [1:0] bank_b_pins,
  input wire logic [1:0] bank_c_pins,
  input wire logic [1:0] bank_d_pins,
  input wire logic pll_locked_raw,
  // outputs to analog core
  output logic use_clock_input,
  output logic [19:0] fin_khz,
  output logic [21:0] fvco_khz,
  output logic [5:0] prescaler_ratio,
  output logic input_doubler_enable,
  output logic [8:0] feedback_divider,
  output pcs_pkg::pcs_bank_cfg_t bank_a_cfg,
  output pcs_pkg::pcs_bank_cfg_t bank_b_cfg,
  output pcs_pkg::pcs_bank_cfg_t bank_c_cfg,
  output pcs_pkg::pcs_bank_cfg_t bank_d_cfg,
  output logic [3:0] frac_integer_part,
  output logic [23:0] frac_frac_part,
  output logic [1:0] frac_post_divider,
  output logic bank_d_source_pick,
  output logic fractional_output_divider,
  output logic divider_resync,
  output logic lock_out
);
  // =====================================================================
  // pin synchronisers: two flops each, stage one read only by stage two
  localparam int SW = 17;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s1_q;
  logic [SW-1:0] pin_s2_q;
  assign pin_raw = {pll_locked_raw, ref_select_pin, bank_d_pins, bank_c_pins,
                    bank_b_pins, bank_a_pins, freq_preset_lo_pins,
                    freq_preset_hi_pins, 3'h0};

  // the spare low bits stay zero and are never read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  logic [1:0] hi_s, lo_s, na_s, nb_s, nc_s, nd_s;
  logic refsel_s, lock_s;
  assign hi_s = pin_s2_q[4:3];
  assign lo_s = pin_s2_q[6:5];
  assign na_s = pin_s2_q[8:7];
  assign nb_s = pin_s2_q[10:9];
  assign nc_s = pin_s2_q[12:11];
  assign nd_s = pin_s2_q[14:13];
  assign refsel_s = pin_s2_q[14+1];
  assign lock_s = pin_s2_q[SW-1];

  // three-level pin arrives as two comparator bits: 11 high, 00 low, else middle
  function automatic pcs_pkg::pcs_level_t lvl(input logic [1:0] p);
    if (p == 2'h3) begin
      lvl = pcs_pkg::PCS_LVL_HIGH;
    end else if (p == 2'h0) begin
      lvl = pcs_pkg::PCS_LVL_LOW;
    end else begin
      lvl = pcs_pkg::PCS_LVL_MID;
    end
  endfunction

  // =====================================================================
  // registers; reset is the power-up state, so all defaults return with it
  logic [31:0] ctl_q, pll_q, bka_q, bkb_q, bkc_q, bkd_q, frac_q;
  logic resync_req;
  assign resync_req = reg_wr && reg_addr == `PCS_ADDR_CTL &&
                      reg_wdata[`PCS_CTL_RESYNC_BIT]; // R10

  // source bits reset to zero: pins govern at power-up
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_q <= `PCS_CTL_RST; // R1 R4
    end else if (reg_wr && reg_addr == `PCS_ADDR_CTL) begin
      ctl_q <= {27'h0, reg_wdata[4:0]}; // R2, resync bit not stored R20
    end
  end

  // config registers always accept writes; pin control just ignores them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pll_q <= `PCS_PLL_RST; // R4
      bka_q <= `PCS_BANK_RST;
      bkb_q <= `PCS_BANK_RST;
      bkc_q <= `PCS_BANK_RST;
      bkd_q <= `PCS_BANK_RST;
      frac_q <= `PCS_FRAC_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `PCS_ADDR_PLL: pll_q <= reg_wdata; // R5
        `PCS_ADDR_BANK_A: bka_q <= reg_wdata; // R6
        `PCS_ADDR_BANK_B: bkb_q <= reg_wdata; // R6
        `PCS_ADDR_BANK_C: bkc_q <= reg_wdata; // R6
        `PCS_ADDR_BANK_D: bkd_q <= reg_wdata; // R7
        `PCS_ADDR_FRAC: frac_q <= {8'h0, reg_wdata[23:0]}; // R7
        default: ;
      endcase
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PCS_ADDR_CTL: reg_rdata <= ctl_q;
        `PCS_ADDR_PLL: reg_rdata <= pll_q;
        `PCS_ADDR_BANK_A: reg_rdata <= bka_q;
        `PCS_ADDR_BANK_B: reg_rdata <= bkb_q;
        `PCS_ADDR_BANK_C: reg_rdata <= bkc_q;
        `PCS_ADDR_BANK_D: reg_rdata <= bkd_q;
        `PCS_ADDR_FRAC: reg_rdata <= frac_q;
        `PCS_ADDR_STAT: reg_rdata <= {29'h0, lock_s, refsel_s, 1'b0};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // =====================================================================
  // frequency preset decode, independent of the reference choice
  pcs_pkg::pcs_preset_t preset;
  always_comb begin
    preset.fvco_khz = 22'd2500000; // R14
    preset.fin_khz = 20'd50000;
    case (lvl(hi_s))
      pcs_pkg::PCS_LVL_HIGH: begin
        case (lvl(lo_s)) // R13
          pcs_pkg::PCS_LVL_HIGH: begin
            preset.fin_khz = 20'd38880;
            preset.fvco_khz = 22'd2488320;
          end
          pcs_pkg::PCS_LVL_MID: begin
            preset.fin_khz = 20'd38400;
            preset.fvco_khz = 22'd2457600;
          end
          default: preset.fin_khz = 20'd31250;
        endcase
      end
      pcs_pkg::PCS_LVL_MID: begin
        case (lvl(lo_s)) // R14
          pcs_pkg::PCS_LVL_HIGH: preset.fin_khz = 20'd312500;
          pcs_pkg::PCS_LVL_MID: preset.fin_khz = 20'd125000;
          default: preset.fin_khz = 20'd156250;
        endcase
      end
      default: begin
        case (lvl(lo_s)) // R14
          pcs_pkg::PCS_LVL_HIGH: preset.fin_khz = 20'd100000;
          pcs_pkg::PCS_LVL_MID: preset.fin_khz = 20'd25000;
          default: preset.fin_khz = 20'd50000;
        endcase
      end
    endcase
  end

  // pll group: presets from pins, or the register fields
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fin_khz <= 20'h0;
      fvco_khz <= 22'h0;
      prescaler_ratio <= 6'h01;
      input_doubler_enable <= 1'b0;
      feedback_divider <= 9'h019;
      use_clock_input <= 1'b0;
      lock_out <= 1'b0;
    end else begin
      use_clock_input <= refsel_s; // R11 R12 R15
      lock_out <= lock_s; // R17 R18
      fin_khz <= preset.fin_khz; // R15
      fvco_khz <= preset.fvco_khz;
      if (ctl_q[`PCS_CTL_PLL_BIT]) begin
        prescaler_ratio <= pll_q[`PCS_PLL_PS_LSB +: 6]; // R5
        input_doubler_enable <= pll_q[`PCS_PLL_FDP_BIT]; // R16 left to host
        feedback_divider <= pll_q[`PCS_PLL_M_LSB +: 9];
      end else begin
        // pin presets: doubler for slow inputs, prescale for fast ones
        prescaler_ratio <= preset.fin_khz > 20'd200000 ? 6'h02 : 6'h01;
        input_doubler_enable <= preset.fin_khz < 20'd100000;
        feedback_divider <= preset.fin_khz < 20'd100000 ? 9'h020 : 9'h010;
      end
    end
  end

  // =====================================================================
  // banks; pin control applies one setting to every output of a bank
  function automatic pcs_pkg::pcs_bank_cfg_t pin_bank(input logic [1:0] p);
    pin_bank = '0;
    case (lvl(p))
      pcs_pkg::PCS_LVL_HIGH: pin_bank.div = 8'h04;
      pcs_pkg::PCS_LVL_MID: pin_bank.div = 8'h08;
      default: pin_bank.div = 8'h10;
    endcase
  endfunction

  function automatic pcs_pkg::pcs_bank_cfg_t reg_bank(input logic [31:0] r, input int n);
    reg_bank.div = r[`PCS_BK_DIV_LSB +: 8]; // R6
    reg_bank.bank_pd = r[`PCS_BK_PD_BIT];
    reg_bank.out_pd = r[`PCS_BK_OPD_LSB +: 4] & 4'((1 << n) - 1); // R19
    reg_bank.style = r[`PCS_BK_STY_LSB +: 4] & 4'((1 << n) - 1);
    reg_bank.swing = r[`PCS_BK_AMP_LSB +: 8] & 8'((1 << (2 * n)) - 1);
  endfunction

  logic [3:0] use_reg;
  logic [1:0] bank_pins [4];
  logic [31:0] bank_regs [4];
  int bank_n [4];
  pcs_pkg::pcs_bank_cfg_t eff [4];
  pcs_pkg::pcs_bank_cfg_t live_q [4];
  assign use_reg = ctl_q[`PCS_CTL_D_BIT:`PCS_CTL_A_BIT];
  assign bank_pins = '{na_s, nb_s, nc_s, nd_s};
  assign bank_regs = '{bka_q, bkb_q, bkc_q, bkd_q};
  assign bank_n = '{NUM_A, NUM_B, NUM_C, NUM_D};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bank
      pcs_cfg_if bif ();
      assign bif.use_reg = use_reg[g]; // R2
      assign bif.pin_cfg = pin_bank(bank_pins[g]);
      assign bif.reg_cfg = reg_bank(bank_regs[g], bank_n[g]);
      assign eff[g] = bif.eff_cfg;
      pcs_bank_sel u_sel (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(bif)
      );
      // divider takes a new value only on resync; others act at once
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          live_q[g] <= '0;
        end else begin
          live_q[g] <= eff[g];
          if (!divider_resync) begin
            live_q[g].div <= live_q[g].div; // R10
          end
        end
      end
    end
  endgenerate

  assign bank_a_cfg = live_q[0];
  assign bank_b_cfg = live_q[1];
  assign bank_c_cfg = live_q[2];
  assign bank_d_cfg = live_q[3];

  // =====================================================================
  // resync: one pulse of four cycles per written one, clears itself
  logic [2:0] rs_cnt_q;
  logic [1:0] nd_prev_q;
  logic pins_moved;
  // a move on the bank d pins outside a resync pulse costs the fractional output until the next resync
  assign pins_moved = nd_s != nd_prev_q; // R8

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rs_cnt_q <= 3'(`PCS_RESYNC_CYC); // power-up acts as a resync R8
    end else if (resync_req) begin
      rs_cnt_q <= 3'(`PCS_RESYNC_CYC); // R8 R10 R20
    end else if (rs_cnt_q != 3'h0) begin
      rs_cnt_q <= rs_cnt_q - 3'h1;
    end
  end

  assign divider_resync = rs_cnt_q != 3'h0;

  // bank d fractional path; drops when pins move, back on resync
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nd_prev_q <= 2'h0;
      fractional_output_divider <= 1'b0;
      frac_integer_part <= 4'h0;
      frac_frac_part <= 24'h0;
      frac_post_divider <= 2'h0;
      bank_d_source_pick <= 1'b0;
    end else begin
      nd_prev_q <= nd_s;
      if (use_reg[3]) begin
        bank_d_source_pick <= bkd_q[`PCS_BD_SRC_BIT]; // R7
        if (divider_resync) begin
          frac_integer_part <= bkd_q[`PCS_BD_FINT_LSB +: 4];
          frac_frac_part <= frac_q[23:0];
          frac_post_divider <= bkd_q[`PCS_BD_DIVF_LSB +: 2];
        end
      end else begin
        bank_d_source_pick <= 1'b0;
      end
      if (divider_resync) begin
        fractional_output_divider <= use_reg[3] & bkd_q[`PCS_BD_FRAC_BIT]; // R8
      end else if (pins_moved) begin
        fractional_output_divider <= 1'b0; // R8
      end
    end
  end
endmodule // pcs_top

// *** tb/pcs_top_sva.sv ***
`timescale 1ns/1ns
`include "pcs_defs.svh"
// ====================================================================
// checker on the top ports; one clock domain, so default clocking
module pcs_top_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] freq_preset_hi_pins,
  input wire logic [1:0] freq_preset_lo_pins,
  input wire logic ref_select_pin,
  input wire logic pll_locked_raw,
  input wire logic use_clock_input,
  input wire logic [19:0] fin_khz,
  input wire logic [21:0] fvco_khz,
  input wire pcs_pkg::pcs_bank_cfg_t bank_a_cfg,
  input wire pcs_pkg::pcs_bank_cfg_t bank_d_cfg,
  input wire logic divider_resync,
  input wire logic lock_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // cycles since reset release; pin checks wait until the syncs have filled
  logic [3:0] up_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) up_q <= 4'h0;
    else if (up_q != 4'hF) up_q <= up_q + 4'h1;
  end
  // ====================================================================
  // resync pulse and what may raise it
  a_resync_len: assert property ($rose(divider_resync) |->
    divider_resync [*4] ##1 !divider_resync) else $error("resync pulse length wrong");
  a_resync_cause: assert property ($rose(divider_resync) |->
    !$past(rst_n, 1) || !$past(rst_n, 2) ||
    $past(reg_wr && reg_addr == `PCS_ADDR_CTL && reg_wdata[`PCS_CTL_RESYNC_BIT]))
    else $error("resync without cause");
  a_div_hold: assert property (!$stable(bank_a_cfg.div) || !$stable(bank_d_cfg.div) |->
    divider_resync || $past(divider_resync)) else $error("divider moved outside resync");
  // ====================================================================
  // lock and reference pins
  a_lock_rise: assert property ($rose(pll_locked_raw) |-> ##[1:4] lock_out)
    else $error("lock not reported");
  a_lock_fall: assert property ($fell(pll_locked_raw) |-> ##[1:4] !lock_out)
    else $error("unlock not reported");
  a_ref_follow: assert property ($stable(ref_select_pin) [*5] ##0 (up_q == 4'hF) |->
    use_clock_input == ref_select_pin) else $error("reference select mismatch");
  // ====================================================================
  // preset decode
  a_vco_2500: assert property ($stable({freq_preset_hi_pins, freq_preset_lo_pins}) [*6]
    ##0 (up_q == 4'hF && freq_preset_hi_pins != 2'b11) |->
    fvco_khz == 22'h2625A0) else $error("vco preset wrong");
  a_fin_low: assert property ($stable({freq_preset_hi_pins, freq_preset_lo_pins}) [*6]
    ##0 (up_q == 4'hF && freq_preset_hi_pins == 2'b11 && freq_preset_lo_pins == 2'b00) |->
    fin_khz == 20'h07A12 && fvco_khz == 22'h2625A0) else $error("low preset wrong");
  // read data only stands in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule // pcs_top_sva

bind pcs_top pcs_top_sva chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .freq_preset_hi_pins(freq_preset_hi_pins), .freq_preset_lo_pins(freq_preset_lo_pins),
  .ref_select_pin(ref_select_pin), .pll_locked_raw(pll_locked_raw),
  .use_clock_input(use_clock_input), .fin_khz(fin_khz), .fvco_khz(fvco_khz),
  .bank_a_cfg(bank_a_cfg), .bank_d_cfg(bank_d_cfg), .divider_resync(divider_resync),
  .lock_out(lock_out));

// *** tb/pcs_host_model.sv ***
`timescale 1ns/1ns
`include "pcs_defs.svh"
// ====================================================================
// host processor on the register port; signals move just after a rising edge
module pcs_host_model (
  input wire logic clk_sys,
  input wire logic [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released write data is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // data taken in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // every divider change is followed by a resync write
  task automatic resync(input logic [31:0] ctl);
    wr(`PCS_ADDR_CTL, ctl | 32'h0000_0100);
  endtask
endmodule // pcs_host_model

// *** tb/pll_config_source_select_test.sv ***
`timescale 1ns/1ns
`include "pcs_defs.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, (exp), (got)); end end
module pll_config_source_select_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] hi_pins = 2'b00;
  logic [1:0] lo_pins = 2'b00;
  logic ref_pin = 1'b0;
  logic lock_raw = 1'b0;
  logic [1:0] bk_pins [4] = '{2'b00, 2'b01, 2'b11, 2'b00};
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, use_clk, lock_out, resync, doubler, src_pick, frac_on;
  logic [19:0] fin;
  logic [21:0] fvco;
  logic [5:0] ps;
  logic [8:0] fb;
  logic [3:0] fint;
  logic [23:0] ffrac;
  logic [1:0] fdiv;
  pcs_pkg::pcs_bank_cfg_t cfg_v [4];
  int failures = 0;
  int checks_done = 0;
  integer seed = 32'h8146F439;
  // preset inputs in kHz, indexed by high level * 3 + low level
  logic [19:0] fin_tab [9] = '{20'h0C350, 20'h061A8, 20'h186A0, 20'h2625A, 20'h1E848,
    20'h4C4B4, 20'h07A12, 20'h09600, 20'h097E0};
  // ====================================================================
  // expectation helpers
  function automatic logic [21:0] exp_vco(int i);
    exp_vco = (i == 7) ? 22'h258000 : (i == 8) ? 22'h25F800 : 22'h2625A0;
  endfunction
  // middle level has two comparator codes; both are exercised
  function automatic logic [1:0] lvl(int i, logic alt);
    lvl = (i == 0) ? 2'b00 : (i == 2) ? 2'b11 : {alt, ~alt};
  endfunction
  // banks c and d have two outputs, so their unused output slots read as zero
  function automatic pcs_pkg::pcs_bank_cfg_t exp_bank(logic [31:0] w, int k);
    logic [3:0] m;
    logic [7:0] s;
    m = (k < 2) ? 4'hF : 4'h3;
    s = (k < 2) ? 8'hFF : 8'h0F;
    exp_bank = {w[7:0], w[8], w[15:12] & m, w[19:16] & m, w[27:20] & s};
  endfunction
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always #10 clk_sys = ~clk_sys;
  pcs_host_model host_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  pcs_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .freq_preset_hi_pins(hi_pins), .freq_preset_lo_pins(lo_pins), .ref_select_pin(ref_pin),
    .bank_a_pins(bk_pins[0]), .bank_b_pins(bk_pins[1]), .bank_c_pins(bk_pins[2]),
    .bank_d_pins(bk_pins[3]), .pll_locked_raw(lock_raw), .use_clock_input(use_clk),
    .fin_khz(fin), .fvco_khz(fvco), .prescaler_ratio(ps), .input_doubler_enable(doubler),
    .feedback_divider(fb), .bank_a_cfg(cfg_v[0]), .bank_b_cfg(cfg_v[1]),
    .bank_c_cfg(cfg_v[2]), .bank_d_cfg(cfg_v[3]), .frac_integer_part(fint),
    .frac_frac_part(ffrac), .frac_post_divider(fdiv), .bank_d_source_pick(src_pick),
    .fractional_output_divider(frac_on), .divider_resync(resync), .lock_out(lock_out));
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    #400000;
    failures++;
    final_report();
  end
  // ====================================================================
  // main sequence
  initial begin : main
    logic [31:0] d;
    logic [31:0] w [4];
    logic [31:0] fw;
    int k;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("resync_after_reset", 1'b1, resync)
    host_u.rd(`PCS_ADDR_CTL, d);
    `CHK("ctl_reset", `PCS_CTL_RST, d)
    host_u.rd(`PCS_ADDR_PLL, d);
    `CHK("pll_reset", `PCS_PLL_RST, d)
    host_u.rd(`PCS_ADDR_BANK_A, d);
    `CHK("bank_reset", `PCS_BANK_RST, d)
    host_u.rd(8'h20, d);
    `CHK("unmapped", 32'h0000_0000, d)
    // every preset, reference picked at random
    for (k = 0; k < 9; k++) begin
      @(posedge clk_sys);
      hi_pins <= lvl(k / 3, 1'($random(seed)));
      lo_pins <= lvl(k % 3, 1'($random(seed)));
      ref_pin <= 1'($random(seed));
      repeat (8) @(posedge clk_sys);
      #1;
      `CHK("fin", fin_tab[k], fin)
      `CHK("fvco", exp_vco(k), fvco)
      `CHK("use_clock_input", ref_pin, use_clk)
    end
    // doubler alone sets the comparison rate, prescaler left at one
    host_u.wr(`PCS_ADDR_PLL, 32'h0001_9101);
    host_u.rd(`PCS_ADDR_PLL, d);
    `CHK("pll_reg_stored", 32'h0001_9101, d)
    for (k = 0; k < 4; k++) begin
      w[k] = $random(seed);
      host_u.wr(`PCS_ADDR_BANK_A + 8'(4 * k), w[k]);
    end
    fw = $random(seed);
    host_u.wr(`PCS_ADDR_FRAC, fw);
    host_u.wr(`PCS_ADDR_CTL, 32'h0000_001F);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("prescaler", 6'h01, ps)
    `CHK("doubler", 1'b1, doubler)
    `CHK("feedback", 9'h019, fb)
    host_u.resync(32'h0000_001F);
    repeat (10) @(posedge clk_sys);
    #1;
    for (k = 0; k < 4; k++) `CHK("bank_cfg", exp_bank(w[k], k), cfg_v[k])
    `CHK("frac_int", w[3][27:24], fint)
    `CHK("frac_part", fw[23:0], ffrac)
    `CHK("post_div", w[3][29:28], fdiv)
    `CHK("src_pick", w[3][30], src_pick)
    host_u.rd(`PCS_ADDR_CTL, d);
    `CHK("ctl_selfclear", 32'h0000_001F, d)
    // pin activity must not reach register-governed bank or pll settings, but a bank d pin move drops the fractional output
    @(posedge clk_sys);
    for (k = 0; k < 3; k++) bk_pins[k] <= 2'($random(seed));
    bk_pins[3] <= ~bk_pins[3];
    lo_pins <= ~lo_pins;
    repeat (8) @(posedge clk_sys);
    #1;
    for (k = 0; k < 4; k++) `CHK("bank_cfg_kept", exp_bank(w[k], k), cfg_v[k])
    `CHK("prescaler_kept", 6'h01, ps)
    `CHK("frac_dropped", 1'b0, frac_on)
    host_u.resync(32'h0000_001F);
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK("frac_on", w[3][31], frac_on)
    // glitch-free divider move on bank a: power down, change, resync, power up
    w[0] = w[0] | 32'h0000_0100;
    host_u.wr(`PCS_ADDR_BANK_A, w[0]);
    w[0] = (w[0] ^ 32'h0000_0001) & ~32'h0000_0100;
    host_u.wr(`PCS_ADDR_BANK_A, w[0] | 32'h0000_0100);
    host_u.resync(32'h0000_001F);
    host_u.wr(`PCS_ADDR_BANK_A, w[0]);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("bank_a_back_up", exp_bank(w[0], 0), cfg_v[0])
    host_u.wr(`PCS_ADDR_CTL, 32'h0000_0000);
    for (k = 0; k < 4; k++) begin
      host_u.rd(`PCS_ADDR_BANK_A + 8'(4 * k), d);
      `CHK("bank_reg_kept", w[k], d)
    end
    // power loss mid-run: written registers fall back to their defaults
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    host_u.rd(`PCS_ADDR_PLL, d);
    `CHK("pll_after_loss", `PCS_PLL_RST, d)
    @(posedge clk_sys);
    lock_raw <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("lock_high", 1'b1, lock_out)
    host_u.rd(`PCS_ADDR_STAT, d);
    `CHK("stat_lock", {29'h0, 1'b1, ref_pin, 1'b0}, d)
    @(posedge clk_sys);
    lock_raw <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("lock_low", 1'b0, lock_out)
    final_report();
  end
endmodule // pll_config_source_select_test
